// File: shp_host_port.sv
// Functional notes
// - Strap sampled once: 0 SPI, 1 I2C
// - Two 7-bit pages over 8-bit space
// - Writing 0x01 to 0x7F toggles page
// - SCK level at select picks bit order
// - 7-bit address, 8-bit data, reset when deselected
// - First address bit: 1 read, 0 write
// - Burst increments address after each byte
// - Input line ignored during read data
// - MSB first: flag, A6..A0, D7..D0
// - I2C slave, 7-bit address, 100/400 kbit/s
// - I2C write: device, register, data bytes
// - Slave address: fixed part plus select pins
// - I2C burst auto-increments the address
// - I2C burst stops at 0x7F, no wrap
module shp_host_port
    import shp_pkg::*;
#(
    parameter logic [4:0] I2C_FIXED_ADDR = I2C_FIXED_ADDR_DEF
) (
    // System
    input  wire logic       clk,
    input  wire logic       rst,
    // Interface select strap
    input  wire logic       if_select_strap,
    // Serial pins
    input  wire logic       sck_scl,
    input  wire logic       si_sda_in,
    output logic            si_sda_out,
    output logic            si_sda_oe,
    input  wire logic       chip_select_or_addr_bit0,
    input  wire logic       serial_out_or_addr_bit1_in,
    output logic            serial_out_or_addr_bit1_out,
    output logic            serial_out_or_addr_bit1_oe,
    // Register file
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata,
    // Status
    output logic            mode_valid,
    output logic            i2c_mode,
    output logic            page_sel
);
    // Pin synchronisers
    logic [SYNC_W-1:0] sync1_ff, sync2_ff;
    logic              sck_d_ff, cs_d_ff;
    wire  sck_s   = sync2_ff[0];
    wire  sda_s   = sync2_ff[1];
    wire  cs_s    = sync2_ff[2];
    wire  so_s    = sync2_ff[3];
    wire  strap_s = sync2_ff[4];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_ff <= '1;
            sync2_ff <= '1;
            sck_d_ff <= 1'b0;
            cs_d_ff  <= 1'b1;
        end else begin
            sync1_ff <= {if_select_strap, serial_out_or_addr_bit1_in, chip_select_or_addr_bit0,
                         si_sda_in, sck_scl};
            sync2_ff <= sync1_ff;
            sck_d_ff <= sck_s;
            cs_d_ff  <= cs_s;
        end
    end

    // Start-up interface selection
    logic [STRAP_CNT_W-1:0] strap_cnt_ff;
    logic                   mode_valid_ff, i2c_mode_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_cnt_ff  <= '0;
            mode_valid_ff <= 1'b0;
            i2c_mode_ff   <= 1'b0;
        end else if (!mode_valid_ff) begin
            strap_cnt_ff <= STRAP_CNT_W'(strap_cnt_ff + 1'b1);
            if (strap_cnt_ff == STRAP_CNT_W'(STRAP_SAMPLE_CYC)) begin
                mode_valid_ff <= 1'b1;
                i2c_mode_ff   <= (strap_s == STRAP_I2C);
            end
        end
    end

    wire spi_act  = mode_valid_ff & ~i2c_mode_ff & ~cs_s;
    wire i2c_en   = mode_valid_ff & i2c_mode_ff;
    wire cs_fall  = cs_d_ff & ~cs_s;
    wire sck_rise = sck_s & ~sck_d_ff;
    wire sck_fall = ~sck_s & sck_d_ff;

    // Shared read return
    logic       rd_pend_ff, rd_page_ff, page_ff;
    wire        rd_valid = rd_pend_ff;
    wire  [7:0] rd_data  = rd_page_ff ? {7'h00, page_ff} : reg_rdata;

    // SPI engine
    logic       lsb_ff, phase_ff, dir_ff, so_ff, spi_wr_ff, spi_rd_ff;
    logic [2:0] bit_ff;
    logic [6:0] spi_addr_ff, spi_acc_addr_ff;
    logic [7:0] spi_sh_ff, spi_tx_ff, spi_wdata_ff;
    wire  [7:0] spi_byte  = shift_in(spi_sh_ff, sda_s, lsb_ff);
    wire        byte_end  = sck_rise && (bit_ff == SPI_LAST_BIT);
    wire        cmd_read  = lsb_ff ? spi_byte[0] : spi_byte[7];
    wire  [6:0] cmd_addr  = lsb_ff ? spi_byte[7:1] : spi_byte[6:0];
    wire  [6:0] spi_next  = 7'(spi_addr_ff + ADDR_STEP);
    wire        tx_bit    = lsb_ff ? spi_tx_ff[0] : spi_tx_ff[7];
    wire  [7:0] tx_shift  = lsb_ff ? {1'b0, spi_tx_ff[7:1]} : {spi_tx_ff[6:0], 1'b0};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {lsb_ff, phase_ff, dir_ff, so_ff, spi_wr_ff, spi_rd_ff} <= '0;
            bit_ff <= '0;
            spi_addr_ff <= '0;
            spi_acc_addr_ff <= '0;
            spi_sh_ff <= '0;
            spi_tx_ff <= '0;
            spi_wdata_ff <= '0;
        end else if (!spi_act) begin
            phase_ff <= 1'b0;
            bit_ff <= '0;
            so_ff <= 1'b0;
            spi_wr_ff <= 1'b0;
            spi_rd_ff <= 1'b0;
        end else begin
            spi_wr_ff <= 1'b0;
            spi_rd_ff <= 1'b0;
            if (cs_fall) begin
                lsb_ff <= sck_s;
            end
            if (sck_fall && phase_ff && dir_ff == DIR_READ) begin
                so_ff <= tx_bit;
                spi_tx_ff <= tx_shift;
            end
            if (rd_valid) begin
                spi_tx_ff <= rd_data;
            end
            if (sck_rise) begin
                spi_sh_ff <= spi_byte;
                bit_ff <= 3'(bit_ff + 3'h1);
            end
            if (byte_end && !phase_ff) begin
                phase_ff <= 1'b1;
                dir_ff <= cmd_read;
                spi_addr_ff <= cmd_addr;
                spi_acc_addr_ff <= cmd_addr;
                spi_rd_ff <= (cmd_read == DIR_READ);
            end else if (byte_end && dir_ff == DIR_READ) begin
                spi_addr_ff <= spi_next;
                spi_acc_addr_ff <= spi_next;
                spi_rd_ff <= 1'b1;
            end else if (byte_end) begin
                spi_wr_ff <= 1'b1;
                spi_wdata_ff <= spi_byte;
                spi_acc_addr_ff <= spi_addr_ff;
                spi_addr_ff <= spi_next;
            end
        end
    end

    // I2C engine
    logic       i2c_sda_oe, i2c_wr, i2c_rd;
    logic [6:0] i2c_addr;
    logic [7:0] i2c_wdata;

    shp_i2c_slave #(
        .FIXED_ADDR (I2C_FIXED_ADDR)
    ) u_i2c (
        .clk        (clk),
        .rst        (rst),
        .en         (i2c_en),
        .scl        (sck_s),
        .sda        (sda_s),
        .asel_lo    (cs_s),
        .asel_hi    (so_s),
        .sda_oe     (i2c_sda_oe),
        .acc_wr     (i2c_wr),
        .acc_rd     (i2c_rd),
        .acc_addr   (i2c_addr),
        .acc_wdata  (i2c_wdata),
        .rd_valid   (rd_valid),
        .rd_data    (rd_data)
    );

    // Access merge and page handling
    wire       acc_wr    = i2c_mode_ff ? i2c_wr : spi_wr_ff;
    wire       acc_rd    = i2c_mode_ff ? i2c_rd : spi_rd_ff;
    wire [6:0] acc_addr  = i2c_mode_ff ? i2c_addr : spi_acc_addr_ff;
    wire [7:0] acc_wdata = i2c_mode_ff ? i2c_wdata : spi_wdata_ff;
    wire       page_hit  = (acc_addr == PAGE_REG_ADDR);
    wire       page_flip = acc_wr && page_hit && (acc_wdata == PAGE_TOGGLE_VAL);

    logic [7:0] reg_addr_ff, reg_wdata_ff;
    logic       reg_wr_ff, reg_rd_ff, pg_rd_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            page_ff <= PAGE_RESET;
            reg_addr_ff <= '0;
            reg_wdata_ff <= '0;
            {reg_wr_ff, reg_rd_ff, pg_rd_ff, rd_pend_ff, rd_page_ff} <= '0;
        end else begin
            if (page_flip) begin
                page_ff <= ~page_ff;
            end
            if (acc_wr || acc_rd) begin
                reg_addr_ff <= {page_ff, acc_addr};
                reg_wdata_ff <= acc_wdata;
            end
            reg_wr_ff <= acc_wr && !page_hit;
            reg_rd_ff <= acc_rd && !page_hit;
            pg_rd_ff <= acc_rd && page_hit;
            rd_pend_ff <= reg_rd_ff || pg_rd_ff;
            rd_page_ff <= pg_rd_ff;
        end
    end

    assign reg_addr   = reg_addr_ff;
    assign reg_wdata  = reg_wdata_ff;
    assign reg_wr     = reg_wr_ff;
    assign reg_rd     = reg_rd_ff;
    assign mode_valid = mode_valid_ff;
    assign i2c_mode   = i2c_mode_ff;
    assign page_sel   = page_ff;
    assign si_sda_out = 1'b0;
    assign si_sda_oe  = i2c_en & i2c_sda_oe;
    assign serial_out_or_addr_bit1_out = so_ff;
    assign serial_out_or_addr_bit1_oe  = spi_act;

    a_strap_once: assert property (@(posedge clk) disable iff (rst)
        mode_valid_ff && $past(mode_valid_ff) |-> $stable(i2c_mode_ff))
        else $error("Interface selection changed after start-up");
    a_page_toggle: assert property (@(posedge clk) disable iff (rst)
        page_flip |=> page_ff != $past(page_ff))
        else $error("Page register write did not toggle the page");
    a_page_local: assert property (@(posedge clk) disable iff (rst)
        reg_wr_ff || reg_rd_ff |-> reg_addr_ff[6:0] != PAGE_REG_ADDR)
        else $error("Page register access leaked to the register file");
    a_lsb_capture: assert property (@(posedge clk) disable iff (rst)
        spi_act && cs_fall |=> lsb_ff == $past(sck_s))
        else $error("Bit order not taken from the clock level");
    a_spi_deselect: assert property (@(posedge clk) disable iff (rst)
        cs_s |=> !phase_ff && bit_ff == 3'h0 && !spi_wr_ff && !spi_rd_ff)
        else $error("SPI logic active while deselected");
    a_spi_dir: assert property (@(posedge clk) disable iff (rst)
        spi_act && byte_end && !phase_ff |=> spi_rd_ff == $past(cmd_read))
        else $error("Direction flag misread");
    a_spi_burst: assert property (@(posedge clk) disable iff (rst)
        spi_act && byte_end && phase_ff |=> spi_addr_ff == 7'($past(spi_addr_ff) + ADDR_STEP))
        else $error("Burst address did not advance");
    a_read_return: assert property (@(posedge clk) disable iff (rst)
        acc_rd |-> ##2 rd_valid)
        else $error("Read data not returned two cycles after request");
endmodule : shp_host_port

// File: shp_pkg.sv
package shp_pkg;
    // Clock and strap timing
    localparam int CLK_PERIOD_NS    = 5;
    localparam int STRAP_SAMPLE_NS  = 1000;
    localparam int STRAP_SAMPLE_CYC = (STRAP_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRAP_CNT_W      = 8;
    localparam logic STRAP_I2C      = 1'b1;

    // Serial framing
    localparam logic       DIR_READ        = 1'b1;
    localparam logic [2:0] SPI_LAST_BIT    = 3'h7;
    localparam logic [3:0] I2C_BYTE_BITS   = 4'h8;
    localparam logic [3:0] I2C_MSB_IDX     = 4'h7;
    localparam logic [7:0] I2C_IDLE_BYTE   = 8'hFF;
    // Arbitrary default for the fixed part of the slave address
    localparam logic [4:0] I2C_FIXED_ADDR_DEF = 5'h0E;

    // Register space
    localparam logic       PAGE_RESET      = 1'b0;
    localparam logic [6:0] PAGE_REG_ADDR   = 7'h7F;
    localparam logic [7:0] PAGE_TOGGLE_VAL = 8'h01;
    localparam logic [6:0] BURST_LAST_ADDR = 7'h7F;
    localparam logic [6:0] ADDR_STEP       = 7'h01;

    localparam int SYNC_W = 5;

    typedef enum logic [2:0] {
        I2_IDLE  = 3'b000,
        I2_DEV   = 3'b001,
        I2_REG   = 3'b010,
        I2_WDATA = 3'b011,
        I2_RDATA = 3'b100,
        I2_WAIT  = 3'b101
    } shp_i2c_state_t;

    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b, input logic lsb);
        return lsb ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction : shift_in
endpackage : shp_pkg

// File: shp_i2c_slave.sv
module shp_i2c_slave
    import shp_pkg::*;
#(
    parameter logic [4:0] FIXED_ADDR = I2C_FIXED_ADDR_DEF
) (
    // System
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       en,
    // Synchronised pins
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       asel_lo,
    input  wire logic       asel_hi,
    output logic            sda_oe,
    // Register access
    output logic            acc_wr,
    output logic            acc_rd,
    output logic [6:0]      acc_addr,
    output logic [7:0]      acc_wdata,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_data
);
    shp_i2c_state_t state_ff;
    logic [3:0] cnt_ff;
    logic [7:0] sh_ff, tx_ff, wdata_ff;
    logic [6:0] addr_ff, acc_addr_ff;
    logic       ack_ff, oe_ff, over_ff, wr_ff, rd_ff, scl_d_ff, sda_d_ff;

    wire scl_rise  = scl & ~scl_d_ff;
    wire scl_fall  = ~scl & scl_d_ff;
    wire start_det = scl & scl_d_ff & sda_d_ff & ~sda;
    wire stop_det  = scl & scl_d_ff & ~sda_d_ff & sda;
    wire busy      = (state_ff != I2_IDLE) && (state_ff != I2_WAIT);
    wire byte_done = (cnt_ff == I2C_BYTE_BITS);
    wire dev_match = (sh_ff[7:1] == {FIXED_ADDR, asel_hi, asel_lo});
    wire at_last   = (addr_ff == BURST_LAST_ADDR);
    wire [2:0] tx_idx = 3'(I2C_MSB_IDX - cnt_ff);
    wire [6:0] addr_inc = 7'(addr_ff + ADDR_STEP);

    assign sda_oe    = oe_ff;
    assign acc_wr    = wr_ff;
    assign acc_rd    = rd_ff;
    assign acc_addr  = acc_addr_ff;
    assign acc_wdata = wdata_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= I2_IDLE;
            cnt_ff <= '0;
            sh_ff <= '0;
            tx_ff <= '0;
            wdata_ff <= '0;
            addr_ff <= '0;
            acc_addr_ff <= '0;
            {ack_ff, oe_ff, over_ff, wr_ff, rd_ff} <= '0;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl;
            sda_d_ff <= sda;
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            if (rd_valid) begin
                tx_ff <= rd_data;
            end
            if (!en || stop_det) begin
                state_ff <= I2_IDLE;
                oe_ff <= 1'b0;
                ack_ff <= 1'b0;
            end else if (start_det) begin
                state_ff <= I2_DEV;
                cnt_ff <= '0;
                oe_ff <= 1'b0;
                ack_ff <= 1'b0;
            end else if (scl_rise && busy) begin
                if (!ack_ff) begin
                    sh_ff <= shift_in(sh_ff, sda, 1'b0);
                    cnt_ff <= 4'(cnt_ff + 4'h1);
                end else if (state_ff == I2_RDATA && !oe_ff) begin
                    if (sda) begin
                        state_ff <= I2_WAIT;
                    end else if (at_last || over_ff) begin
                        over_ff <= 1'b1;
                        tx_ff <= I2C_IDLE_BYTE;
                    end else begin
                        addr_ff <= addr_inc;
                        acc_addr_ff <= addr_inc;
                        rd_ff <= 1'b1;
                    end
                end
            end else if (scl_fall && busy) begin
                if (ack_ff) begin
                    ack_ff <= 1'b0;
                    cnt_ff <= '0;
                    oe_ff <= (state_ff == I2_RDATA) ? ~tx_ff[I2C_MSB_IDX[2:0]] : 1'b0;
                end else if (byte_done) begin
                    ack_ff <= 1'b1;
                    unique case (state_ff)
                        I2_DEV: begin
                            oe_ff <= dev_match;
                            if (!dev_match) begin
                                state_ff <= I2_WAIT;
                            end else if (sh_ff[0] == DIR_READ) begin
                                state_ff <= I2_RDATA;
                                acc_addr_ff <= addr_ff;
                                rd_ff <= ~over_ff;
                                if (over_ff) begin
                                    tx_ff <= I2C_IDLE_BYTE;
                                end
                            end else begin
                                state_ff <= I2_REG;
                            end
                        end
                        I2_REG: begin
                            oe_ff <= 1'b1;
                            addr_ff <= sh_ff[6:0];
                            over_ff <= 1'b0;
                            state_ff <= I2_WDATA;
                        end
                        I2_WDATA: begin
                            oe_ff <= 1'b1;
                            if (!over_ff) begin
                                wr_ff <= 1'b1;
                                wdata_ff <= sh_ff;
                                acc_addr_ff <= addr_ff;
                                if (at_last) begin
                                    over_ff <= 1'b1;
                                end else begin
                                    addr_ff <= addr_inc;
                                end
                            end
                        end
                        I2_RDATA: begin
                            oe_ff <= 1'b0;
                        end
                        default: begin
                            oe_ff <= 1'b0;
                        end
                    endcase
                end else if (state_ff == I2_RDATA) begin
                    oe_ff <= ~tx_ff[tx_idx];
                end
            end
        end
    end

    a_i2c_addr_ack: assert property (@(posedge clk) disable iff (rst)
        en && !start_det && !stop_det && scl_fall && !ack_ff && byte_done && state_ff == I2_DEV
        |=> sda_oe == $past(dev_match))
        else $error("Device address acknowledge does not follow the match");
    a_i2c_no_wrap: assert property (@(posedge clk) disable iff (rst)
        over_ff && $past(over_ff) |-> !acc_wr && !acc_rd)
        else $error("Burst access past the last address");
    a_i2c_burst_inc: assert property (@(posedge clk) disable iff (rst)
        acc_wr && !over_ff |-> addr_ff == 7'(acc_addr_ff + ADDR_STEP))
        else $error("Burst address not advancing");
endmodule : shp_i2c_slave

// File: shp_host_model.sv
module shp_host_model (
    // Clock
    input  wire logic clk,
    // Serial pins
    output logic      sck,
    output logic      mosi,
    output logic      cs_n,
    output logic      sda_pull,
    input  wire logic miso,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        cs_n = 1'b1;
        sda_pull = 1'b0;
    end
    // Half of the 160 ns link period
    task automatic half();
        repeat (16) @(posedge clk);
    endtask : half
    // Drive after the falling edge, sample at the rising edge
    task automatic spi_bit(input logic b, output logic r);
        sck <= 1'b0;
        mosi <= b;
        half();
        sck <= 1'b1;
        r = miso;
        half();
    endtask : spi_bit
    task automatic spi_access(input logic lsb, input logic rd, input logic [6:0] a,
                              input int n, inout logic [31:0] d);
        logic r;
        int   j;
        sck <= lsb;
        half();
        cs_n <= 1'b0;
        half();
        spi_bit(rd, r);
        for (int k = 0; k < 7; k++)
            spi_bit(a[lsb ? k : 6 - k], r);
        for (int k = 0; k < 8 * n; k++) begin
            j = 8 * (k / 8) + (lsb ? k % 8 : 7 - k % 8);
            spi_bit(rd ? 1'($urandom()) : d[j], r);
            if (rd)
                d[j] = r;
        end
        sck <= lsb;
        half();
        cs_n <= 1'b1;
        mosi <= ~mosi;
        half();
    endtask : spi_access
    task automatic i2c_bit(input logic b, output logic r);
        sda_pull <= ~b;
        half();
        sck <= 1'b1;
        half();
        r = sda;
        sck <= 1'b0;
        half();
    endtask : i2c_bit
    // Start or repeated start: data falls while the clock is high
    task automatic i2c_start();
        sda_pull <= 1'b0;
        half();
        sck <= 1'b1;
        half();
        sda_pull <= 1'b1;
        half();
        sck <= 1'b0;
        half();
    endtask : i2c_start
    task automatic i2c_stop();
        sda_pull <= 1'b1;
        half();
        sck <= 1'b1;
        half();
        sda_pull <= 1'b0;
        half();
    endtask : i2c_stop
    // Eight data bits MSB first, then the acknowledge bit
    task automatic i2c_byte(input logic [8:0] tx, output logic [8:0] rx);
        for (int k = 8; k >= 0; k--)
            i2c_bit(tx[k], rx[k]);
    endtask : i2c_byte
endmodule : shp_host_model

// File: tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import shp_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        strap = 1'b0;
    logic        a_lo = 1'b1;
    logic        a_hi = 1'b0;
    logic [7:0]  reg_rdata = 8'h00;
    logic        sck, mosi, cs_n, sda_pull, sda, so, so_oe, sda_out, sda_oe;
    logic [7:0]  reg_addr, reg_wdata;
    logic        reg_wr, reg_rd, mode_valid, i2c_mode, page_sel;
    logic [15:0] exp_q[$];
    int          bad_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    localparam logic [6:0] DEV = {I2C_FIXED_ADDR_DEF, 2'b01};
    // Open-drain data line with pull-up
    assign sda = ~(sda_pull | sda_oe);
    always #2.5 clk = ~clk;
    shp_host_model u_shp_host_model (.clk(clk), .sck(sck), .mosi(mosi), .cs_n(cs_n),
        .sda_pull(sda_pull), .miso(so), .sda(sda));
    shp_host_port u_shp_host_port (.clk(clk), .rst(rst), .if_select_strap(strap),
        .sck_scl(sck), .si_sda_in(strap ? sda : mosi), .si_sda_out(sda_out),
        .si_sda_oe(sda_oe), .chip_select_or_addr_bit0(strap ? a_lo : cs_n),
        .serial_out_or_addr_bit1_in(so_oe ? so : a_hi),
        .serial_out_or_addr_bit1_out(so), .serial_out_or_addr_bit1_oe(so_oe),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mode_valid(mode_valid), .i2c_mode(i2c_mode),
        .page_sel(page_sel));
    // Register file answers one cycle after the read pulse
    always @(posedge clk)
        if (reg_rd === 1'b1)
            reg_rdata <= reg_addr ^ 8'hA5;
    task automatic results();
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // Every write pulse takes the oldest expected write
    always @(posedge clk) begin
        if (reg_wr === 1'b1)
            chk({reg_addr, reg_wdata}, exp_q.size() ? exp_q.pop_front() : 16'hXXXX);
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            bad_count++;
            results();
        end
    end
    task automatic do_reset(input logic s);
        rst <= 1'b1;
        strap <= s;
        repeat (16) @(posedge clk);
        chk({reg_wr, reg_rd, mode_valid, page_sel}, 16'h0000);
        rst <= 1'b0;
        repeat (STRAP_SAMPLE_CYC + 8) @(posedge clk);
        chk({mode_valid, i2c_mode, page_sel}, {13'h0000, 1'b1, s, 1'b0});
    endtask : do_reset
    task automatic i2c_wr(input logic [7:0] b);
        logic [8:0] rx;
        u_shp_host_model.i2c_byte({b, 1'b1}, rx);
        chk(rx[0], 1'b0);
    endtask : i2c_wr
    initial begin
        logic [31:0] d;
        logic [8:0]  rx;
        void'($urandom(32'h2f6e6b2c));
        do_reset(1'b0);
        strap <= 1'b1;
        repeat (4) @(posedge clk);
        chk(i2c_mode, 1'b0);
        strap <= 1'b0;
        for (int l = 0; l < 2; l++) begin
            d = $urandom();
            u_shp_host_model.spi_access(l, 1'b0, 7'h11, 0, d);
            for (int i = 0; i < 3; i++)
                exp_q.push_back({8'h10 + 8'(32 * l + i), d[8*i +: 8]});
            u_shp_host_model.spi_access(l, 1'b0, 7'h10 + 7'(32 * l), 3, d);
            u_shp_host_model.spi_access(l, 1'b1, 7'h40 + 7'(l), 2, d);
            for (int i = 0; i < 2; i++)
                chk(d[8*i +: 8], (8'h40 + 8'(l + i)) ^ 8'hA5);
        end
        d = 32'h02;
        u_shp_host_model.spi_access(1'b0, 1'b0, PAGE_REG_ADDR, 1, d);
        chk(page_sel, 1'b0);
        d = 32'h01;
        u_shp_host_model.spi_access(1'b0, 1'b0, PAGE_REG_ADDR, 1, d);
        chk(page_sel, 1'b1);
        u_shp_host_model.spi_access(1'b1, 1'b1, PAGE_REG_ADDR, 1, d);
        chk(d[7:0], 8'h01);
        d = $urandom();
        exp_q.push_back({8'h83, d[7:0]});
        u_shp_host_model.spi_access(1'b0, 1'b0, 7'h03, 1, d);
        do_reset(1'b1);
        u_shp_host_model.i2c_start();
        u_shp_host_model.i2c_byte({DEV ^ 7'h01, 2'b01}, rx);
        chk(rx[0], 1'b1);
        u_shp_host_model.i2c_stop();
        d = $urandom();
        exp_q.push_back({8'h7D, d[7:0]});
        exp_q.push_back({8'h7E, d[15:8]});
        u_shp_host_model.i2c_start();
        i2c_wr({DEV, 1'b0});
        i2c_wr(8'h7D);
        i2c_wr(d[7:0]);
        i2c_wr(d[15:8]);
        i2c_wr(8'h00);
        i2c_wr(d[23:16]);
        u_shp_host_model.i2c_stop();
        u_shp_host_model.i2c_start();
        i2c_wr({DEV, 1'b0});
        i2c_wr(8'h7F);
        i2c_wr(8'h01);
        u_shp_host_model.i2c_start();
        i2c_wr({DEV, 1'b0});
        i2c_wr(8'h05);
        exp_q.push_back({8'h85, d[31:24]});
        i2c_wr(d[31:24]);
        u_shp_host_model.i2c_stop();
        chk(page_sel, 1'b1);
        u_shp_host_model.i2c_start();
        i2c_wr({DEV, 1'b0});
        i2c_wr(8'h7E);
        u_shp_host_model.i2c_start();
        i2c_wr({DEV, 1'b1});
        for (int i = 0; i < 3; i++) begin
            u_shp_host_model.i2c_byte({8'hFF, i == 2}, rx);
            chk(rx[8:1], i == 0 ? 8'h5B : i == 1 ? 8'h01 : 8'hFF);
        end
        u_shp_host_model.i2c_stop();
        a_lo <= 1'b0;
        a_hi <= 1'b1;
        u_shp_host_model.i2c_start();
        i2c_wr({I2C_FIXED_ADDR_DEF, 2'b10, 1'b0});
        u_shp_host_model.i2c_stop();
        chk({sda_out, so_oe, sda_oe}, 16'h0000);
        chk(16'(exp_q.size()), 16'h0000);
        results();
    end
endmodule : tb
